//--- ioc_top.sv
// digital i/o block: 24 lines in four direction groups, 32-bit event
// counter and link status lamp, registers on a classic wishbone slave
// assumes link status inputs come from logic on the same clock
//
// Contract
// - lamp steadily lit while attached and no transfer is running
// - lamp blinks continuously while transfers with the host run
// - lamp flashes exactly three times when communication is first established
// - lamp indication cannot be switched off by any setting
// - twenty four lines in three eight-bit ports A, B, C
// - direction is chosen per port, per half for port C, and applied to every line of it
// - input port reports high level as 1 and ground as 0
// - one 32-bit event counter fed by the counter input pin
// - counter adds one per rising edge, ignores falling edges
// - no count is lost for input signals up to 1 MHz
// - after reset every line is input with drivers off
// - port C splits into two four-bit halves with own directions
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ioc_top
	import ioc_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC
) (
	input  wire logic          clock,
	input  wire logic          reset,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	input  wire logic [23:0]   general_digital_line_i,
	output logic      [23:0]   general_digital_line_o,
	output logic      [23:0]   general_digital_line_oe_n,
	input  wire logic          event_count_input,
	input  wire logic          host_attached,
	input  wire logic          comm_up,
	input  wire logic          xfer_active,
	output logic               status_lamp
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
		reg_hit = (adr[7:2] == off[7:2]);
	endfunction

	// which direction group a line belongs to
	function automatic int unsigned group_of(input int unsigned line);
		if (line < 8)
			group_of = DIR_A;
		else if (line < 16)
			group_of = DIR_B;
		else if (line < 20)
			group_of = DIR_CLO;
		else
			group_of = DIR_CHI;
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		lane_merge = (new_v & m) | (old_v & ~m);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [3:0]        dir_q;
	logic [23:0]       out_q;
	logic [31:0]       count_q;
	logic [31:0]       count_d;
	logic [23:0]       line_sync;
	logic              cnt_sync;
	logic              cnt_prev_q;
	logic              cnt_rise;
	logic              bus_req;
	logic              bus_wr;
	logic [31:0]       rd_d;
	logic [31:0]       half_cnt_q;
	logic              tick;
	logic [2:0]        flash_cnt_q;
	ioc_lamp_e         lamp_state_q;
	ioc_lamp_e         lamp_state_d;
	logic              lamp_q;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	ioc_sync #(.WIDTH(LINE_W)) u_line_sync (
		.clock (clock),
		.reset (reset),
		.pin   (general_digital_line_i),
		.level (line_sync)
	);

	ioc_sync #(.WIDTH(1)) u_cnt_sync (
		.clock (clock),
		.reset (reset),
		.pin   (event_count_input),
		.level (cnt_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: one wait state, ack for one cycle, unmapped reads zero

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr  = bus_req & wb_we_i;

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req;
	end

	always_comb begin
		rd_d = DATA_ZERO;
		if (reg_hit(wb_adr_i, OFF_DIR))
			rd_d[3:0] = dir_q;
		else if (reg_hit(wb_adr_i, OFF_OUT))
			rd_d[23:0] = out_q;
		else if (reg_hit(wb_adr_i, OFF_IN))
			rd_d[23:0] = line_sync;
		else if (reg_hit(wb_adr_i, OFF_COUNT))
			rd_d = count_q;
		else if (reg_hit(wb_adr_i, OFF_STATUS)) begin
			rd_d[ST_ATTACHED] = host_attached;
			rd_d[ST_COMM] = comm_up;
			rd_d[ST_XFER] = xfer_active;
			rd_d[ST_LAMP] = lamp_q;
			rd_d[ST_STATE_LO +: 2] = lamp_state_q;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			wb_dat_o <= DATA_ZERO;
		else if (bus_req && !wb_we_i)
			wb_dat_o <= rd_d;
		else
			wb_dat_o <= DATA_ZERO;
	end

	////////////////////////////////////////////////////////////////////////
	// direction and output data

	logic [31:0] dir_merge;
	logic [31:0] out_merge;
	assign dir_merge = lane_merge({28'h000_0000, dir_q}, wb_dat_i, wb_sel_i);
	assign out_merge = lane_merge({8'h00, out_q}, wb_dat_i, wb_sel_i);

	// one bit per group, so port C halves are set independently
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			dir_q <= DIR_RESET;
		else if (bus_wr && reg_hit(wb_adr_i, OFF_DIR))
			dir_q <= dir_merge[3:0];
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			out_q <= OUT_RESET;
		else if (bus_wr && reg_hit(wb_adr_i, OFF_OUT))
			out_q <= out_merge[23:0];
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			general_digital_line_o <= OUT_RESET;
		else
			general_digital_line_o <= out_q;
	end

	// enables are active low; every line of a group follows its bit
	for (genvar i = 0; i < LINE_W; i++) begin : g_oe
		always_ff @(posedge clock or posedge reset) begin
			if (reset)
				general_digital_line_oe_n[i] <= 1'b1;
			else
				general_digital_line_oe_n[i] <= ~dir_q[group_of(i)];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event counter: a 500 ns pulse spans 20 clocks, far above the two
	// cycles the synchroniser and edge detector need, so 1 MHz is safe

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			cnt_prev_q <= 1'b0;
		else
			cnt_prev_q <= cnt_sync;
	end

	assign cnt_rise = cnt_sync & ~cnt_prev_q;

	// a write clears, but an edge in the same cycle still counts
	always_comb begin
		count_d = count_q;
		if (bus_wr && reg_hit(wb_adr_i, OFF_COUNT))
			count_d = COUNT_RESET;
		if (cnt_rise)
			count_d = count_d + 32'h0000_0001;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			count_q <= COUNT_RESET;
		else
			count_q <= count_d;
	end

	////////////////////////////////////////////////////////////////////////
	// status lamp: no register touches it, so it cannot be disabled

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			half_cnt_q <= 32'h0000_0000;
		else if (lamp_state_q != LAMP_FLASH && lamp_state_d == LAMP_FLASH)
			half_cnt_q <= 32'h0000_0000;
		else if (half_cnt_q == 32'(BLINK_HALF_CYCLES - 1))
			half_cnt_q <= 32'h0000_0000;
		else
			half_cnt_q <= half_cnt_q + 32'h0000_0001;
	end

	assign tick = (half_cnt_q == 32'(BLINK_HALF_CYCLES - 1));

	always_comb begin
		lamp_state_d = lamp_state_q;
		case (lamp_state_q)
			LAMP_DARK: begin
				if (host_attached)
					lamp_state_d = LAMP_WAIT;
			end
			LAMP_WAIT: begin
				if (comm_up)
					lamp_state_d = LAMP_FLASH;
			end
			LAMP_FLASH: begin
				if (tick && flash_cnt_q == FLASH_TICKS - 3'h1)
					lamp_state_d = LAMP_RUN;
			end
			LAMP_RUN: begin
				lamp_state_d = LAMP_RUN;
			end
			default: begin
				lamp_state_d = LAMP_DARK;
			end
		endcase
		if (!host_attached)
			lamp_state_d = LAMP_DARK;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			lamp_state_q <= LAMP_DARK;
		else
			lamp_state_q <= lamp_state_d;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			flash_cnt_q <= 3'h0;
		else if (lamp_state_q != LAMP_FLASH)
			flash_cnt_q <= 3'h0;
		else if (tick)
			flash_cnt_q <= flash_cnt_q + 3'h1;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			lamp_q <= 1'b0;
		else begin
			case (lamp_state_d)
				LAMP_DARK:
					lamp_q <= 1'b0;
				LAMP_WAIT:
					lamp_q <= 1'b1;
				LAMP_FLASH: begin
					if (lamp_state_q != LAMP_FLASH)
						lamp_q <= 1'b0;
					else if (tick)
						lamp_q <= ~lamp_q;
				end
				LAMP_RUN: begin
					if (!xfer_active)
						lamp_q <= 1'b1;
					else if (tick)
						lamp_q <= ~lamp_q;
				end
				default:
					lamp_q <= 1'b0;
			endcase
		end
	end

	assign status_lamp = lamp_q;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	property p_lamp_steady;
		lamp_state_q == LAMP_RUN && host_attached && !xfer_active |=> status_lamp;
	endproperty
	a_lamp_steady: assert property (p_lamp_steady) else $error("lamp not steady");

	property p_lamp_blink;
		lamp_state_q == LAMP_RUN && host_attached && xfer_active && tick
			|=> status_lamp != $past(status_lamp);
	endproperty
	a_lamp_blink: assert property (p_lamp_blink) else $error("lamp did not toggle");

	property p_flash_end;
		lamp_state_q == LAMP_FLASH && host_attached && tick && flash_cnt_q == 3'h6
			|=> lamp_state_q == LAMP_RUN && !$past(status_lamp);
	endproperty
	a_flash_end: assert property (p_flash_end) else $error("flash phase length wrong");

	property p_flash_start;
		lamp_state_q == LAMP_WAIT && host_attached && comm_up
			|=> lamp_state_q == LAMP_FLASH && !status_lamp && flash_cnt_q == 3'h0;
	endproperty
	a_flash_start: assert property (p_flash_start) else $error("flash did not start");

	property p_dir_port_a;
		##1 general_digital_line_oe_n[7:0] == {8{~$past(dir_q[DIR_A])}};
	endproperty
	a_dir_port_a: assert property (p_dir_port_a) else $error("port A enable mismatch");

	property p_dir_port_c;
		##1 general_digital_line_oe_n[23:20] == {4{~$past(dir_q[DIR_CHI])}}
			&& general_digital_line_oe_n[19:16] == {4{~$past(dir_q[DIR_CLO])}};
	endproperty
	a_dir_port_c: assert property (p_dir_port_c) else $error("port C halves mismatch");

	property p_in_read;
		bus_req && !wb_we_i && reg_hit(wb_adr_i, OFF_IN)
			|=> wb_ack_o && wb_dat_o[23:0] == $past(line_sync) && wb_dat_o[31:24] == 8'h00;
	endproperty
	a_in_read: assert property (p_in_read) else $error("input read mismatch");

	property p_count_inc;
		cnt_rise && !(bus_wr && reg_hit(wb_adr_i, OFF_COUNT))
			|=> count_q == $past(count_q) + 32'h0000_0001;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("edge not counted");

	property p_count_hold;
		!cnt_rise && !(bus_wr && reg_hit(wb_adr_i, OFF_COUNT)) |=> $stable(count_q);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved without edge");

	property p_count_wrap;
		cnt_rise && count_q == 32'hFFFF_FFFF && !bus_wr |=> count_q == 32'h0000_0000;
	endproperty
	a_count_wrap: assert property (p_count_wrap) else $error("counter did not wrap");

	property p_rise_single;
		cnt_rise |=> !cnt_rise;
	endproperty
	a_rise_single: assert property (p_rise_single) else $error("double edge pulse");

	property p_input_mode;
		dir_q == DIR_RESET |=> general_digital_line_oe_n == 24'hFF_FFFF;
	endproperty
	a_input_mode: assert property (p_input_mode) else $error("driver on in input mode");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	c_flash_done: cover property (lamp_state_q == LAMP_FLASH ##1 lamp_state_q == LAMP_RUN);
	c_count_edge: cover property (cnt_rise);
	c_dir_write: cover property (bus_wr && reg_hit(wb_adr_i, OFF_DIR));
	c_blink_run: cover property (lamp_state_q == LAMP_RUN && xfer_active && tick);

endmodule

//--- ioc_pkg.sv
// constants shared by the digital i/o, event counter and status lamp block
// assumes a single 40 MHz clock and a 32-bit classic wishbone register bus
package ioc_pkg;

	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned BLINK_HALF_MS   = 100;
	localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int unsigned CNT_MAX_HZ      = 1_000_000;
	localparam int unsigned CNT_MIN_PULSE_NS = 500;
	localparam int unsigned CNT_MIN_PULSE_CYC = (CNT_MIN_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;

	localparam int unsigned LINE_W   = 24;
	localparam int unsigned GROUP_N  = 4;
	localparam int unsigned COUNT_W  = 32;
	localparam int unsigned ADR_W    = 8;
	localparam int unsigned SYNC_N   = 2;

	// register byte offsets
	localparam logic [7:0] OFF_DIR    = 8'h00;
	localparam logic [7:0] OFF_OUT    = 8'h04;
	localparam logic [7:0] OFF_IN     = 8'h08;
	localparam logic [7:0] OFF_COUNT  = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;

	// direction group bits in the direction register, 1 = output
	localparam int unsigned DIR_A   = 0;
	localparam int unsigned DIR_B   = 1;
	localparam int unsigned DIR_CLO = 2;
	localparam int unsigned DIR_CHI = 3;

	// status register fields
	localparam int unsigned ST_ATTACHED = 0;
	localparam int unsigned ST_COMM     = 1;
	localparam int unsigned ST_XFER     = 2;
	localparam int unsigned ST_LAMP     = 3;
	localparam int unsigned ST_STATE_LO = 4;

	localparam logic [3:0]  DIR_RESET   = 4'h0;
	localparam logic [23:0] OUT_RESET   = 24'h00_0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

	// half periods spent in the flash phase: six toggles give three flashes,
	// the seventh half period is the dark gap before the normal indication
	localparam logic [2:0] FLASH_TICKS = 3'h7;

	typedef enum logic [1:0] {
		LAMP_DARK  = 2'b00,
		LAMP_WAIT  = 2'b01,
		LAMP_FLASH = 2'b10,
		LAMP_RUN   = 2'b11
	} ioc_lamp_e;

endpackage

//--- ioc_sync.sv
// multi-bit two stage synchroniser for asynchronous pin inputs
// assumes each bit is independent; no bus coherence is implied
`timescale 1ns/10ps
module ioc_sync
	import ioc_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);

	logic [WIDTH-1:0] meta_q;

	// meta_q is read only by the second stage
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			level  <= '0;
		end else begin
			meta_q <= pin;
			level  <= meta_q;
		end
	end

endmodule

//--- ioc_pin_model.sv
// pin side model: ttl sources on the lines and a pulse source on the counter pin
// assumes active-low enables from the block and the bench clock
`timescale 1ns/10ps
module ioc_pin_model
	import ioc_pkg::*;
#(
	parameter int unsigned HALF = 20
) (
	input  wire logic        clock,
	input  wire logic [23:0] line_o,
	input  wire logic [23:0] oe_n,
	input  wire logic [23:0] ext_level,
	input  wire logic        pulse_run,
	output logic      [23:0] line_i,
	output logic             count_pin,
	output logic      [31:0] edges_made
);
	int unsigned div_q  = 0;
	logic        pin_q  = 1'b0;
	logic [31:0] made_q = 32'h0000_0000;

	// one process owns the pin state; the ports only mirror it
	assign count_pin  = pin_q;
	assign edges_made = made_q;

	// a driven line shows the block's level, a released one the outside source
	assign line_i = (line_o & ~oe_n) | (ext_level & oe_n);

	////////////////////////////////////////////////////////////////////////////////
	// high and low each HALF clocks: 500 ns at 40 MHz, the 1 MHz limit
	// a stop request finishes the high phase so the pin rests low
	always @(posedge clock) begin
		if (pulse_run || pin_q) begin
			if (div_q == HALF - 1) begin
				div_q <= 0;
				pin_q <= ~pin_q;
				if (!pin_q)
					made_q <= made_q + 32'h0000_0001;
			end else begin
				div_q <= div_q + 1;
			end
		end
	end
endmodule

//--- ioc_top_tb.sv
// self-checking bench for ioc_top: lines, event counter, lamp, registers
// assumes ioc_pin_model on the pin side and a 40 MHz clock
`timescale 1ns/10ps
module ioc_top_tb
	import ioc_pkg::*;
;
	typedef struct packed {
		logic [3:0]  dir;
		logic [23:0] outv;
		logic [23:0] oe;
	} ioc_row_s;
	localparam logic [23:0] EXT = 24'hA5_3C96;
	localparam ioc_row_s ROWS [6] = '{
		'{4'h0, 24'h12_3456, 24'hFF_FFFF},
		'{4'h1, 24'h12_3456, 24'hFF_FF00},
		'{4'h2, 24'h65_4321, 24'hFF_00FF},
		'{4'h4, 24'h0F_0F0F, 24'hF0_FFFF},
		'{4'h8, 24'hF0_F0F0, 24'h0F_FFFF},
		'{4'hF, 24'h5A_A55A, 24'h00_0000}};

	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic [31:0] wdat  = 32'h0000_0000;
	logic [3:0]  sel   = 4'hF;
	logic [31:0] rdat;
	logic        ack;
	logic [23:0] line_i;
	logic [23:0] line_o;
	logic [23:0] oe_n;
	logic        cnt_pin;
	logic [31:0] edges;
	logic        run   = 1'b0;
	logic        att   = 1'b0;
	logic        comm  = 1'b0;
	logic        xfer  = 1'b0;
	logic        lamp;
	logic        lamp_prev = 1'b0;
	int unsigned rises = 0;
	int unsigned err_count = 0;
	int unsigned samples_checked = 0;

	initial begin
		forever #12.5 clock = ~clock;
	end

	ioc_top #(.BLINK_HALF_CYCLES(8)) uut (.clock(clock), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.general_digital_line_i(line_i), .general_digital_line_o(line_o),
		.general_digital_line_oe_n(oe_n), .event_count_input(cnt_pin),
		.host_attached(att), .comm_up(comm), .xfer_active(xfer),
		.status_lamp(lamp));

	ioc_pin_model pins (.clock(clock), .line_o(line_o), .oe_n(oe_n),
		.ext_level(EXT), .pulse_run(run), .line_i(line_i),
		.count_pin(cnt_pin), .edges_made(edges));

	always @(posedge clock) begin
		lamp_prev <= lamp;
		if (lamp && !lamp_prev)
			rises <= rises + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= wd;
		for (n = 0; n < 16; n++) begin
			@(posedge clock);
			if (ack === 1'b1)
				break;
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n == 16) begin
			err_count++;
			finish_test();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		int unsigned base;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		chk("oe_n", {8'h00, oe_n}, 32'h00FF_FFFF);
		chk("lamp", {31'h0, lamp}, 32'h0000_0000);
		foreach (ROWS[i]) begin
			wb(1'b1, OFF_DIR, {28'h0, ROWS[i].dir}, d);
			wb(1'b1, OFF_OUT, {8'h00, ROWS[i].outv}, d);
			repeat (4) @(posedge clock);
			chk("oe_n", {8'h00, oe_n}, {8'h00, ROWS[i].oe});
			chk("line_o", {8'h00, line_o & ~oe_n}, {8'h00, ROWS[i].outv & ~ROWS[i].oe});
			wb(1'b0, OFF_IN, 32'h0000_0000, d);
			chk("in", d, {8'h00, (ROWS[i].outv & ~ROWS[i].oe) | (EXT & ROWS[i].oe)});
		end
		// only lane 0 may change when sel holds a single byte
		sel <= 4'h1;
		wb(1'b1, OFF_OUT, 32'hFFFF_FFFF, d);
		sel <= 4'hF;
		wb(1'b0, OFF_OUT, 32'h0000_0000, d);
		chk("out lanes", d, {8'h00, ROWS[5].outv[23:8], 8'hFF});
		wb(1'b1, 8'h20, 32'hFFFF_FFFF, d);
		wb(1'b0, 8'h20, 32'h0000_0000, d);
		chk("unmapped", d, 32'h0000_0000);
		wb(1'b1, OFF_COUNT, 32'h0000_0000, d);
		base = edges;
		run <= 1'b1;
		for (int i = 0; i < 1000 && edges < base + 5; i++)
			@(posedge clock);
		if (edges < base + 5) begin
			err_count++;
			finish_test();
		end
		run <= 1'b0;
		repeat (60) @(posedge clock);
		wb(1'b0, OFF_COUNT, 32'h0000_0000, d);
		chk("count", d, edges - base);
		chk("edges", edges - base, 32'h0000_0005);
		wb(1'b1, OFF_COUNT, 32'h0000_0000, d);
		wb(1'b0, OFF_COUNT, 32'h0000_0000, d);
		chk("count clear", d, 32'h0000_0000);
		att <= 1'b1;
		repeat (4) @(posedge clock);
		base = rises;
		repeat (30) @(posedge clock);
		chk("lamp wait", {31'h0, lamp}, 32'h0000_0001);
		chk("wait rises", rises - base, 32'h0000_0000);
		comm <= 1'b1;
		base = rises;
		// seven half periods of 8 clocks: the steady light only rises after 56
		repeat (56) @(posedge clock);
		chk("flashes", rises - base, 32'h0000_0003);
		chk("flash gap", {31'h0, lamp}, 32'h0000_0000);
		repeat (34) @(posedge clock);
		chk("lamp run", {31'h0, lamp}, 32'h0000_0001);
		xfer <= 1'b1;
		base = rises;
		repeat (64) @(posedge clock);
		chk("blinks", {31'h0, rises - base inside {3, 4}}, 32'h0000_0001);
		xfer <= 1'b0;
		for (int a = 0; a <= 16; a += 4)
			wb(1'b1, 8'(a), 32'hFFFF_FFFF, d);
		base = rises;
		repeat (20) @(posedge clock);
		wb(1'b0, OFF_STATUS, 32'h0000_0000, d);
		chk("status", d, 32'h0000_003B);
		chk("steady", rises - base, 32'h0000_0000);
		att <= 1'b0;
		repeat (3) @(posedge clock);
		chk("lamp dark", {31'h0, lamp}, 32'h0000_0000);
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		chk("oe_n", {8'h00, oe_n}, 32'h00FF_FFFF);
		finish_test();
	end
endmodule
